// file: shared/tfm_pkg.sv
/*
 Package for the trip fault memory manager: counter widths, thresholds,
 snapshot field widths and the similar-condition window constants.
 Assumes the monitors deliver engine speed in rpm and load and coolant
 figures as unsigned integers.
*/
package tfm_pkg;
  localparam int unsigned TFM_CNT_W = 7;
  localparam logic [6:0] TFM_LAMP_CLEAR_DRIVES = 7'h03;
  localparam logic [6:0] TFM_LONG_AGE_DRIVES = 7'h28;
  localparam logic [6:0] TFM_SIMILAR_DRIVES = 7'h50;
  localparam logic [6:0] TFM_CNT_ZERO = 7'h00;
  localparam logic [6:0] TFM_CNT_ONE = 7'h01;
  localparam int unsigned TFM_RPM_W = 14;
  localparam int unsigned TFM_LOAD_W = 8;
  localparam int unsigned TFM_TEMP_W = 8;
  localparam logic [13:0] TFM_RPM_WINDOW = 14'h0177;
  // Load tolerance is one tenth: load*10 is compared against ref*9 and ref*11.
  localparam logic [3:0] TFM_LOAD_SCALE = 4'hA;
  localparam logic [3:0] TFM_LOAD_LOW_MUL = 4'h9;
  localparam logic [3:0] TFM_LOAD_HIGH_MUL = 4'hB;
  localparam logic [7:0] TFM_COOLANT_SPLIT = 8'h46;
endpackage : tfm_pkg

// file: hdl/tfm_sat_counter.sv
/*
 Saturating drive counter with clear priority over increment.
 Assumes one clock; clear and increment are single-cycle pulses.
*/
`timescale 1ns/100ps
module tfm_sat_counter
  import tfm_pkg::*;
#(
  parameter int unsigned WIDTH = TFM_CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic incr_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic [WIDTH-1:0] count_o,
  output logic at_limit_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (clear_i) begin
      count_d = '0;
    end else if (incr_i && (count_q < limit_i)) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
  assign at_limit_o = (count_q >= limit_i);
endmodule // tfm_sat_counter

// file: hdl/tfm_similar_match.sv
/*
 Similar-condition comparator: live engine speed, load and coolant against
 the stored snapshot. Purely combinational.
 Assumes all inputs come from the same clock domain.
*/
`timescale 1ns/100ps
module tfm_similar_match
  import tfm_pkg::*;
(
  input wire logic [TFM_RPM_W-1:0] live_rpm_i,
  input wire logic [TFM_LOAD_W-1:0] live_load_i,
  input wire logic [TFM_TEMP_W-1:0] live_temp_i,
  input wire logic [TFM_RPM_W-1:0] snap_rpm_i,
  input wire logic [TFM_LOAD_W-1:0] snap_load_i,
  input wire logic [TFM_TEMP_W-1:0] snap_temp_i,
  output logic match_o
);
  logic [TFM_RPM_W:0] rpm_diff;
  logic rpm_ok;
  logic [TFM_LOAD_W+3:0] load_scaled;
  logic [TFM_LOAD_W+3:0] load_low;
  logic [TFM_LOAD_W+3:0] load_high;
  logic load_ok;
  logic temp_ok;

  always_comb begin
    if (live_rpm_i >= snap_rpm_i) begin
      rpm_diff = {1'b0, live_rpm_i - snap_rpm_i};
    end else begin
      rpm_diff = {1'b0, snap_rpm_i - live_rpm_i};
    end
    rpm_ok = (rpm_diff <= {1'b0, TFM_RPM_WINDOW});
    load_scaled = live_load_i * TFM_LOAD_SCALE;
    load_low = snap_load_i * TFM_LOAD_LOW_MUL;
    load_high = snap_load_i * TFM_LOAD_HIGH_MUL;
    load_ok = (load_scaled >= load_low) && (load_scaled <= load_high);
    temp_ok = ((live_temp_i < TFM_COOLANT_SPLIT) == (snap_temp_i < TFM_COOLANT_SPLIT));
    match_o = rpm_ok && load_ok && temp_ok;
  end
endmodule // tfm_similar_match

// file: hdl/tfm_fault_manager.sv
/*
 Trip fault memory manager for one fault code. One instance per fault code
 keeps its own counters and stored state; the lamp outputs of all instances
 are ORed outside.
 Assumes monitors and the drive-cycle qualifier logic share sys_clk_i and
 deliver one-cycle pulses: a fault detection, an OK result, and an end of
 drive summary carrying the drive's qualifiers. Detection and end of drive
 may not coincide except as documented below.
*/
`timescale 1ns/100ps
module tfm_fault_manager
  import tfm_pkg::*;
#(
  parameter int unsigned CNT_W = TFM_CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic similar_class_i,
  input wire logic fault_detect_i,
  input wire logic ok_detect_i,
  input wire logic drive_end_i,
  input wire logic drive_all_monitored_i,
  input wire logic drive_any_fault_i,
  input wire logic drive_aging_qual_i,
  input wire logic [TFM_RPM_W-1:0] live_rpm_i,
  input wire logic [TFM_LOAD_W-1:0] live_load_i,
  input wire logic [TFM_TEMP_W-1:0] live_temp_i,
  output logic pending_fault_code_o,
  output logic confirmed_fault_code_o,
  output logic fault_indicator_lamp_o,
  output logic [TFM_RPM_W-1:0] pend_snap_rpm_o,
  output logic [TFM_LOAD_W-1:0] pend_snap_load_o,
  output logic [TFM_TEMP_W-1:0] pend_snap_temp_o,
  output logic pend_snap_valid_o,
  output logic [TFM_RPM_W-1:0] conf_snap_rpm_o,
  output logic [TFM_LOAD_W-1:0] conf_snap_load_o,
  output logic [TFM_TEMP_W-1:0] conf_snap_temp_o,
  output logic [CNT_W-1:0] drive_count_o
);
  // Pending and confirmed state.
  logic pend_q;
  logic pend_d;
  logic pend_show_q;
  logic pend_show_d;
  logic psnap_v_q;
  logic psnap_v_d;
  logic conf_q;
  logic conf_d;
  logic conf_show_q;
  logic conf_show_d;
  logic lamp_q;
  logic lamp_d;
  // Trip tracking: whether this trip and the last completed one saw the fault.
  logic fault_this_trip_q;
  logic fault_this_trip_d;
  logic fault_last_trip_q;
  logic fault_last_trip_d;
  // Snapshots: pending from the first trip, confirmed from the second.
  logic [TFM_RPM_W-1:0] prpm_q;
  logic [TFM_RPM_W-1:0] prpm_d;
  logic [TFM_RPM_W-1:0] crpm_q;
  logic [TFM_RPM_W-1:0] crpm_d;
  logic [TFM_LOAD_W-1:0] pload_q;
  logic [TFM_LOAD_W-1:0] pload_d;
  logic [TFM_LOAD_W-1:0] cload_q;
  logic [TFM_LOAD_W-1:0] cload_d;
  logic [TFM_TEMP_W-1:0] ptemp_q;
  logic [TFM_TEMP_W-1:0] ptemp_d;
  logic [TFM_TEMP_W-1:0] ctemp_q;
  logic [TFM_TEMP_W-1:0] ctemp_d;
  // Clean drives counted since the last detection while a code is stored, saturating at all ones.
  logic [CNT_W-1:0] drives_q;
  logic [CNT_W-1:0] drives_d;

  logic second_trip_hit;
  logic lamp_drive;
  logic aging_drive;
  logic similar_drive;
  logic similar_match;
  logic drive_clean;
  logic lamp_off_now;
  logic [CNT_W-1:0] sim_cnt;
  logic lamp_done;
  logic long_done;
  logic sim_done;

  // A detection is a second-trip hit when the previous completed trip also had it.
  assign second_trip_hit = fault_detect_i && fault_last_trip_q;
  assign drive_clean = drive_end_i && !fault_detect_i && !fault_this_trip_q;
  assign lamp_drive = drive_clean && drive_all_monitored_i && !drive_any_fault_i;
  assign aging_drive = drive_clean && drive_aging_qual_i;
  assign similar_drive = drive_clean && similar_match;
  // A malfunction in the cycle the counter tops out clears it, so the lamp
  // stays lit: the clear is taken as winning over the switch-off.
  assign lamp_off_now = lamp_done && !fault_detect_i && !drive_any_fault_i;

  tfm_similar_match u_match (
    .live_rpm_i(live_rpm_i),
    .live_load_i(live_load_i),
    .live_temp_i(live_temp_i),
    .snap_rpm_i(crpm_q),
    .snap_load_i(cload_q),
    .snap_temp_i(ctemp_q),
    .match_o(similar_match)
  );

  // Lamp-clear counter: any detection at all clears it. It only counts while
  // the lamp is lit, so a stale count can never switch off a fresh lamp.
  tfm_sat_counter #(.WIDTH(CNT_W)) u_lamp_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(fault_detect_i || drive_any_fault_i),
    .incr_i(lamp_drive && lamp_q),
    .limit_i(CNT_W'(TFM_LAMP_CLEAR_DRIVES)),
    .count_o(),
    .at_limit_o(lamp_done)
  );

  tfm_sat_counter #(.WIDTH(CNT_W)) u_long_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(fault_detect_i),
    .incr_i(aging_drive && conf_q && !similar_class_i),
    .limit_i(CNT_W'(TFM_LONG_AGE_DRIVES)),
    .count_o(),
    .at_limit_o(long_done)
  );

  tfm_sat_counter #(.WIDTH(CNT_W)) u_sim_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(fault_detect_i),
    .incr_i(similar_drive && conf_q && similar_class_i),
    .limit_i(CNT_W'(TFM_SIMILAR_DRIVES)),
    .count_o(sim_cnt),
    .at_limit_o(sim_done)
  );

  always_comb begin
    pend_d = pend_q;
    pend_show_d = pend_show_q;
    psnap_v_d = psnap_v_q;
    conf_d = conf_q;
    conf_show_d = conf_show_q;
    lamp_d = lamp_q;
    fault_this_trip_d = fault_this_trip_q;
    fault_last_trip_d = fault_last_trip_q;
    prpm_d = prpm_q;
    pload_d = pload_q;
    ptemp_d = ptemp_q;
    crpm_d = crpm_q;
    cload_d = cload_q;
    ctemp_d = ctemp_q;
    drives_d = drives_q;

    if (fault_detect_i) begin
      fault_this_trip_d = 1'b1;
      drives_d = '0;
      if (second_trip_hit) begin
        // Second consecutive trip: confirm with the live data.
        conf_d = 1'b1;
        conf_show_d = 1'b1;
        lamp_d = 1'b1;
        crpm_d = live_rpm_i;
        cload_d = live_load_i;
        ctemp_d = live_temp_i;
        psnap_v_d = 1'b0;
      end else if (!pend_q || !pend_show_q) begin
        // A hidden pending code counts as absent, so a fresh first-trip
        // detection stores and reports it again.
        pend_d = 1'b1;
        pend_show_d = 1'b1;
        psnap_v_d = 1'b1;
        prpm_d = live_rpm_i;
        pload_d = live_load_i;
        ptemp_d = live_temp_i;
      end
    end else if (ok_detect_i) begin
      // An OK result in the trip after a first detection hides the pending code.
      if (fault_last_trip_q && !fault_this_trip_q) begin
        pend_show_d = 1'b0;
      end
      if (similar_class_i) begin
        psnap_v_d = 1'b0;
      end
    end

    if (drive_end_i) begin
      fault_last_trip_d = fault_this_trip_q || fault_detect_i;
      fault_this_trip_d = 1'b0;
      if (drive_clean && (conf_q || pend_q) && (drives_q != {CNT_W{1'b1}})) begin
        drives_d = drives_q + 1'b1;
      end
    end

    // Pending aging, per fault class.
    if (!similar_class_i && lamp_drive && pend_q) begin
      pend_d = 1'b0;
      pend_show_d = 1'b0;
      psnap_v_d = 1'b0;
    end
    if (similar_class_i && conf_q && (sim_cnt != TFM_CNT_ZERO[CNT_W-1:0]) && !fault_detect_i) begin
      pend_d = 1'b0;
      pend_show_d = 1'b0;
    end

    if (lamp_off_now) begin
      lamp_d = 1'b0;
    end
    if (conf_q && !fault_detect_i) begin
      if (!similar_class_i && long_done) begin
        conf_d = 1'b0;
        conf_show_d = 1'b0;
      end
      if (similar_class_i && sim_done) begin
        conf_d = 1'b0;
        conf_show_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pend_q <= 1'b0;
      pend_show_q <= 1'b0;
      psnap_v_q <= 1'b0;
      conf_q <= 1'b0;
      conf_show_q <= 1'b0;
      lamp_q <= 1'b0;
      fault_this_trip_q <= 1'b0;
      fault_last_trip_q <= 1'b0;
      prpm_q <= '0;
      pload_q <= '0;
      ptemp_q <= '0;
      crpm_q <= '0;
      cload_q <= '0;
      ctemp_q <= '0;
      drives_q <= '0;
    end else begin
      pend_q <= pend_d;
      pend_show_q <= pend_show_d;
      psnap_v_q <= psnap_v_d;
      conf_q <= conf_d;
      conf_show_q <= conf_show_d;
      lamp_q <= lamp_d;
      fault_this_trip_q <= fault_this_trip_d;
      fault_last_trip_q <= fault_last_trip_d;
      prpm_q <= prpm_d;
      pload_q <= pload_d;
      ptemp_q <= ptemp_d;
      crpm_q <= crpm_d;
      cload_q <= cload_d;
      ctemp_q <= ctemp_d;
      drives_q <= drives_d;
    end
  end

  assign pending_fault_code_o = pend_q && pend_show_q;
  assign confirmed_fault_code_o = conf_show_q;
  assign fault_indicator_lamp_o = lamp_q;
  assign pend_snap_rpm_o = prpm_q;
  assign pend_snap_load_o = pload_q;
  assign pend_snap_temp_o = ptemp_q;
  assign pend_snap_valid_o = psnap_v_q;
  assign conf_snap_rpm_o = crpm_q;
  assign conf_snap_load_o = cload_q;
  assign conf_snap_temp_o = ctemp_q;
  assign drive_count_o = drives_q;
endmodule // tfm_fault_manager

// file: tb/tfm_fault_manager_sva.sv
/* Checker for one fault manager instance.
 Assumes it is bound to the manager and sees only its ports. */
`timescale 1ns/100ps
module tfm_fault_manager_chk
  import tfm_pkg::*;
#(
  parameter int unsigned CNT_W = TFM_CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic fault_detect_i,
  input wire logic drive_end_i,
  input wire logic drive_all_monitored_i,
  input wire logic drive_any_fault_i,
  input wire logic [TFM_RPM_W-1:0] live_rpm_i,
  input wire logic pending_fault_code_o,
  input wire logic confirmed_fault_code_o,
  input wire logic fault_indicator_lamp_o,
  input wire logic [TFM_RPM_W-1:0] pend_snap_rpm_o,
  input wire logic pend_snap_valid_o,
  input wire logic [CNT_W-1:0] drive_count_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // Helper: whether the last completed trip saw a detection, so that a
  // second-trip hit is not mistaken for a first detection.
  logic trip_hit_q;
  logic last_hit_q;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      trip_hit_q <= 1'b0;
      last_hit_q <= 1'b0;
    end else if (drive_end_i) begin
      last_hit_q <= trip_hit_q || fault_detect_i;
      trip_hit_q <= 1'b0;
    end else if (fault_detect_i) begin
      trip_hit_q <= 1'b1;
    end
  end
  a_first_detect: assert property (
    fault_detect_i && !pending_fault_code_o && !confirmed_fault_code_o && !last_hit_q
    |=> pending_fault_code_o && pend_snap_valid_o) else $error("pending not stored");
  a_snap_capture: assert property (
    fault_detect_i && !pending_fault_code_o && !confirmed_fault_code_o && !last_hit_q
    |=> pend_snap_rpm_o == $past(live_rpm_i)) else $error("snapshot not captured");
  a_confirm_lamp: assert property (
    $rose(confirmed_fault_code_o) |-> fault_indicator_lamp_o && !pend_snap_valid_o
    && $past(fault_detect_i)) else $error("bad confirm");
  a_lamp_off_clean: assert property (
    $fell(fault_indicator_lamp_o) |-> $past(drive_end_i, 2)
    && $past(drive_all_monitored_i, 2) && !$past(drive_any_fault_i, 2))
    else $error("lamp off without clean drive");
  a_detect_holds_lamp: assert property (
    fault_detect_i && fault_indicator_lamp_o |=> fault_indicator_lamp_o [*3])
    else $error("lamp dropped after detection");
  a_other_holds_lamp: assert property (
    drive_any_fault_i && fault_indicator_lamp_o |=> fault_indicator_lamp_o [*3])
    else $error("lamp dropped after other fault");
  a_count_step: assert property (
    drive_count_o != $past(drive_count_o) |-> drive_count_o == TFM_CNT_ZERO
    || ($past(drive_end_i) && drive_count_o == $past(drive_count_o) + 1'b1))
    else $error("drive count jumped");
  a_code_ages_on_drive: assert property (
    $fell(confirmed_fault_code_o) |-> $past(drive_end_i, 2))
    else $error("code aged without drive");
endmodule // tfm_fault_manager_chk

bind tfm_fault_manager tfm_fault_manager_chk #(.CNT_W(CNT_W)) tfm_fault_manager_chk_inst (
  .sys_clk_i, .srst_i, .fault_detect_i, .drive_end_i, .drive_all_monitored_i,
  .drive_any_fault_i, .live_rpm_i, .pending_fault_code_o, .confirmed_fault_code_o,
  .fault_indicator_lamp_o, .pend_snap_rpm_o, .pend_snap_valid_o, .drive_count_o);

// file: tb/tfm_monitor_model.sv
/* Behavioural diagnostic monitors for one fault code.
 Assumes the bench calls its tasks and owns reset. */
`timescale 1ns/100ps
module tfm_monitor_model
  import tfm_pkg::*;
(
  input wire logic sys_clk_i,
  output logic [2:0] ev_o,
  output logic [2:0] qual_o,
  output logic [TFM_RPM_W-1:0] rpm_o,
  output logic [TFM_LOAD_W-1:0] load_o,
  output logic [TFM_TEMP_W-1:0] temp_o
);
  initial begin
    ev_o = 3'h0;
    qual_o = 3'h0;
    set_data(14'h0352, 8'h1E, 8'h50);
  end
  // Events are {detect, ok, drive end}; qualifiers {monitored, aging, other fault}.
  // Qualifiers stand only in the drive-end cycle, as a real summary would.
  task automatic pulse(input logic [2:0] ev, input logic [2:0] q);
    @(posedge sys_clk_i);
    #1;
    ev_o = ev;
    qual_o = q;
    @(posedge sys_clk_i);
    #1;
    ev_o = 3'h0;
    qual_o = 3'h0;
  endtask
  task automatic set_data(input logic [13:0] r, input logic [7:0] l, input logic [7:0] t);
    rpm_o = r;
    load_o = l;
    temp_o = t;
  endtask
endmodule // tfm_monitor_model

// file: tb/test_tfm_fault_manager.sv
/* Bench for the fault manager, one task per scenario.
 Assumes package and design are compiled first. */
`timescale 1ns/100ps
module test_tfm_fault_manager;
  import tfm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cls = 1'b0;
  logic [2:0] ev, q;
  logic [13:0] rpm, psr, csr;
  logic [7:0] load, temp, psl, pst, csl, cst;
  logic [6:0] dcnt;
  logic pend, conf, lamp, psv;
  int mismatches = 0;
  int comparisons = 0;
  tfm_monitor_model tfm_monitor_model_inst (.sys_clk_i(sys_clk_i), .ev_o(ev), .qual_o(q),
    .rpm_o(rpm), .load_o(load), .temp_o(temp));
  tfm_fault_manager tfm_fault_manager_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .similar_class_i(cls), .fault_detect_i(ev[2]), .ok_detect_i(ev[1]),
    .drive_end_i(ev[0]), .drive_all_monitored_i(q[2]), .drive_aging_qual_i(q[1]),
    .drive_any_fault_i(q[0]), .live_rpm_i(rpm), .live_load_i(load), .live_temp_i(temp),
    .pending_fault_code_o(pend), .confirmed_fault_code_o(conf),
    .fault_indicator_lamp_o(lamp), .pend_snap_rpm_o(psr), .pend_snap_load_o(psl),
    .pend_snap_temp_o(pst), .pend_snap_valid_o(psv), .conf_snap_rpm_o(csr),
    .conf_snap_load_o(csl), .conf_snap_temp_o(cst), .drive_count_o(dcnt));
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [13:0] exp, input logic [13:0] act);
    comparisons++;
    if (act !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  // Counter-derived effects land one edge after the counter step.
  task automatic settle();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic detect();
    tfm_monitor_model_inst.pulse(3'h4, 3'h0);
  endtask
  task automatic drive(input logic [2:0] qv, input int n);
    for (int i = 0; i < n; i++) begin
      tfm_monitor_model_inst.pulse(3'h1, qv);
    end
  endtask
  task automatic do_reset(input logic c);
    @(posedge sys_clk_i);
    #1;
    srst_i = 1'b1;
    cls = c;
    repeat (2) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
  endtask
  task automatic two_trip();
    detect();
    chk(14'h1, pend);
    chk(14'h1, psv);
    chk(14'h0352, psr);
    chk(14'h001E, psl);
    chk(14'h0050, pst);
    drive(3'h0, 1);
    detect();
    chk(14'h1, conf);
    chk(14'h1, lamp);
    chk(14'h0, psv);
    chk(14'h0352, csr);
    chk(14'h001E, csl);
    chk(14'h0050, cst);
    chk(14'h0, dcnt);
  endtask
  // Aging drives stay unmonitored so they never move the lamp counter.
  task automatic lamp_and_age();
    do_reset(1'b0);
    two_trip();
    drive(3'h2, 20);
    drive(3'h4, 2);
    chk(14'h0, pend);
    detect();
    drive(3'h5, 1);
    drive(3'h4, 2);
    chk(14'h1, lamp);
    drive(3'h4, 1);
    settle();
    chk(14'h0, lamp);
    drive(3'h2, 39);
    chk(14'h1, conf);
    drive(3'h2, 1);
    settle();
    chk(14'h0, conf);
  endtask
  task automatic ok_trip();
    do_reset(1'b1);
    detect();
    drive(3'h0, 1);
    tfm_monitor_model_inst.pulse(3'h2, 3'h0);
    chk(14'h0, pend);
    chk(14'h0, psv);
  endtask
  // Snapshot is 850 rpm, 30 load, 80 C; each miss breaks one window by one step.
  task automatic similar();
    do_reset(1'b1);
    two_trip();
    // The first drive closes the confirming trip and is never counted.
    tfm_monitor_model_inst.set_data(14'h04CA, 8'h1E, 8'h50);
    drive(3'h0, 2);
    tfm_monitor_model_inst.set_data(14'h04C9, 8'h22, 8'h50);
    drive(3'h0, 1);
    tfm_monitor_model_inst.set_data(14'h04C9, 8'h1E, 8'h45);
    drive(3'h0, 1);
    chk(14'h1, pend);
    tfm_monitor_model_inst.set_data(14'h01DB, 8'h1B, 8'h46);
    drive(3'h0, 1);
    settle();
    chk(14'h0, pend);
    chk(14'h4, dcnt);
    drive(3'h0, 39);
    detect();
    drive(3'h0, 80);
    chk(14'h1, conf);
    drive(3'h0, 1);
    settle();
    chk(14'h0, conf);
  endtask
  initial begin
    #2500000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    lamp_and_age();
    ok_trip();
    similar();
    end_sim();
  end
endmodule // test_tfm_fault_manager
